// file: hw/eem_irq.v
// Sticky event status, enable and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module eem_irq #(
    parameter N = 4
) (
    input wire clk,                // System clock
    input wire rst_b,              // Synchronous reset, active low
    input wire [N-1:0] evt,        // Event levels, set status while high
    input wire clr_wr,             // Write to the clear register
    input wire en_wr,              // Write to the enable register
    input wire [N-1:0] wr_data,    // Write data, low bits
    output reg [N-1:0] sts_r,      // Sticky status
    output reg [N-1:0] en_r,       // Interrupt enables
    output reg irq_r               // Level interrupt
);
    wire [N-1:0] clr_bits;

    assign clr_bits = clr_wr ? wr_data : {N{1'b0}};

    always @(posedge clk) begin
        if (!rst_b) begin
            sts_r <= {N{1'b0}};
            en_r <= {N{1'b0}};
            irq_r <= 1'b0;
        end else begin
            // A new event in the clearing cycle survives the clear
            sts_r <= evt | (sts_r & ~clr_bits);
            if (en_wr) begin
                en_r <= wr_data;
            end
            irq_r <= |(sts_r & en_r);
        end
    end
endmodule
`default_nettype wire

// file: hw/eem_mask_reg.v
// One mask register with write-one-to-set and write-one-to-clear ports
`timescale 1ns/1ps
`default_nettype none
module eem_mask_reg #(
    parameter [31:0] IMPL = 32'hffff_ffff,
    parameter [31:0] RESET_VAL = 32'h0000_0000
) (
    input wire clk,                // System clock
    input wire rst_b,              // Synchronous reset, active low
    input wire set_en,             // Write to the set alias
    input wire clr_en,             // Write to the clear alias
    input wire [31:0] wr_data,     // Bus write data
    input wire [31:0] lane_mask,   // Byte enables expanded to bits
    output wire [31:0] mask_q      // Current mask value
);
    reg [31:0] mask_r;
    reg [31:0] mask_nxt;
    reg [31:0] hit;

    always @* begin
        hit = wr_data & lane_mask & IMPL;
        mask_nxt = mask_r;
        // A zero in the data leaves its mask alone on either alias
        if (set_en) begin
            mask_nxt = mask_r | hit; // R01
        end
        if (clr_en) begin
            mask_nxt = mask_nxt & ~hit; // R17
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            mask_r <= RESET_VAL & IMPL; // R18
        end else begin
            mask_r <= mask_nxt;
        end
    end

    assign mask_q = mask_r & IMPL; // R18
endmodule
`default_nettype wire

// file: hw/eem_regs.vh
// Register map, field positions and reset values of the event mask-set block
// Summary of operation
// (R01) Writing one sets mask; zero leaves it
// (R02) Reads return current mask values
// (R03) Six per-link A copies, events 0, 1
// (R04) Events 2, 3 share one A, B
// (R05) A bits 8..0 enable receive alarms
// (R06) B bit 24 enables encoder word error
// (R07) B bits 20..16 enable buffer alarms
// (R08) B bits 13, 12 enable combiner FIFO alarms
// (R09) B bits 10..8 enable aggregator alarms
// (R10) B bits 3..0 enable transmit alarms
// (R11) Six per-link B copies, events 0, 1
// (R12) Common set register drives non-link masks
// (R13) Common bits 25, 24: write, capture errors
// (R14) Common bits 23..8 enable buffer alarms
// (R15) Source aggregated only while mask one
// (R16) Common bits 1, 0: combiner align errors
// (R17) Clear alias: writing one clears mask
// (R18) Reserved read zero; masks zero after reset
// (R19) Event asserts when raw and mask set
`ifndef EEM_REGS_VH
`define EEM_REGS_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define EEM_NUM_LINKS 6
`define EEM_NUM_EVENTS 4
`define EEM_NUM_BANKS 14
`define EEM_SHARED_BANK 12

// ----------------------------------------------------------------------
// Byte offsets, one aligned word per register
// ----------------------------------------------------------------------
`define EEM_A_SET_BASE 12'h000
`define EEM_B_SET_BASE 12'h040
`define EEM_C_SET_BASE 12'h080
`define EEM_C_MSTS_BASE 12'h0c0
`define EEM_A_CLR_BASE 12'h100
`define EEM_B_CLR_BASE 12'h140
`define EEM_C_CLR_BASE 12'h180
`define EEM_IRQ_STS 12'h200
`define EEM_IRQ_CLR 12'h204
`define EEM_IRQ_EN 12'h208

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EEM_A_RX_SYNC_CHANGE_BIT 0
`define EEM_A_RX_COMMA_FREE_BIT 8
`define EEM_B_TX_SYNC_CHANGE_BIT 0
`define EEM_B_AGG_HEADER_BIT 8
`define EEM_B_COMB_FIFO_OVER_BIT 12
`define EEM_B_BUF_IN_DMA_OVER_BIT 16
`define EEM_B_ENC_CTRL_WORD_BIT 24
`define EEM_C_COMB0_ALIGN_BIT 0
`define EEM_C_BUF_IN_FIFO_OVER_BIT 8
`define EEM_C_CAPTURE_BUS_BIT 24
`define EEM_C_PKT_OUT_WRITE_BIT 25

// ----------------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------------
`define EEM_A_IMPL 32'h1f11_ffff
`define EEM_B_IMPL 32'h011f_370f
`define EEM_C_IMPL 32'h03ff_ff03
`define EEM_MASK_RESET 32'h0000_0000
`define EEM_IRQ_RESET 4'h0

`endif

// file: hw/eem_top.v
// Event mask-set block: Wishbone slave, mask banks, event aggregation
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "eem_regs.vh"
module eem_top #(
    parameter NL = 6
) (
    input wire clk,                    // System clock, 250 MHz
    input wire rst_b,                  // Synchronous reset, active low
    input wire wb_cyc_i,               // Wishbone cycle
    input wire wb_stb_i,               // Wishbone strobe
    input wire wb_we_i,                // Wishbone write enable
    input wire [11:0] wb_adr_i,        // Wishbone byte address
    input wire [3:0] wb_sel_i,         // Wishbone byte selects
    input wire [31:0] wb_dat_i,        // Wishbone write data
    output reg [31:0] wb_dat_o,        // Wishbone read data
    output reg wb_ack_o,               // Wishbone acknowledge
    input wire [NL*32-1:0] link_raw_a, // Per-link raw status A
    input wire [NL*32-1:0] link_raw_b, // Per-link raw status B
    input wire [31:0] common_raw,      // Common raw status
    output reg [3:0] antenna_event_out, // Aggregated event outputs
    output wire irq_o                  // Level interrupt
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function [31:0] lane_expand;
        input [3:0] sel;
        begin
            lane_expand = {{8{sel[3]}}, {8{sel[2]}},
                           {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // True when addr falls in a region of cnt words starting at base
    function in_region;
        input [11:0] addr;
        input [11:0] base;
        input [31:0] cnt;
        reg [11:0] diff;
        begin
            diff = addr - base;
            in_region = (addr >= base) && (diff[11:2] < cnt[9:0]);
        end
    endfunction

    function [3:0] word_index;
        input [11:0] addr;
        input [11:0] base;
        reg [11:0] diff;
        begin
            diff = addr - base;
            word_index = diff[5:2];
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // Requests are taken one cycle before ack; ack lasts one cycle and
    // the slave stays idle while ack is high so a held strobe counts once.
    wire req_take;
    wire wr_take;
    wire [11:0] adr;
    wire [31:0] lanes;

    assign req_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_take = req_take & wb_we_i;
    assign adr = {wb_adr_i[11:2], 2'b00};
    assign lanes = lane_expand(wb_sel_i);

    wire hit_a_set;
    wire hit_b_set;
    wire hit_c_set;
    wire hit_a_clr;
    wire hit_b_clr;
    wire hit_c_clr;
    wire hit_c_msts;
    wire hit_irq_sts;
    wire hit_irq_clr;
    wire hit_irq_en;
    wire [3:0] idx_a_set;
    wire [3:0] idx_b_set;
    wire [3:0] idx_c_set;
    wire [3:0] idx_a_clr;
    wire [3:0] idx_b_clr;
    wire [3:0] idx_c_clr;
    wire [3:0] idx_c_msts;

    assign hit_a_set = in_region(adr, `EEM_A_SET_BASE, `EEM_NUM_BANKS);
    assign hit_b_set = in_region(adr, `EEM_B_SET_BASE, `EEM_NUM_BANKS);
    assign hit_c_set = in_region(adr, `EEM_C_SET_BASE, `EEM_NUM_EVENTS);
    assign hit_a_clr = in_region(adr, `EEM_A_CLR_BASE, `EEM_NUM_BANKS);
    assign hit_b_clr = in_region(adr, `EEM_B_CLR_BASE, `EEM_NUM_BANKS);
    assign hit_c_clr = in_region(adr, `EEM_C_CLR_BASE, `EEM_NUM_EVENTS);
    assign hit_c_msts = in_region(adr, `EEM_C_MSTS_BASE, `EEM_NUM_EVENTS);
    assign hit_irq_sts = (adr == `EEM_IRQ_STS);
    assign hit_irq_clr = (adr == `EEM_IRQ_CLR);
    assign hit_irq_en = (adr == `EEM_IRQ_EN);
    assign idx_a_set = word_index(adr, `EEM_A_SET_BASE);
    assign idx_b_set = word_index(adr, `EEM_B_SET_BASE);
    assign idx_c_set = word_index(adr, `EEM_C_SET_BASE);
    assign idx_a_clr = word_index(adr, `EEM_A_CLR_BASE);
    assign idx_b_clr = word_index(adr, `EEM_B_CLR_BASE);
    assign idx_c_clr = word_index(adr, `EEM_C_CLR_BASE);
    assign idx_c_msts = word_index(adr, `EEM_C_MSTS_BASE);

    // ------------------------------------------------------------------
    // Mask banks
    // ------------------------------------------------------------------
    // Banks 0-5 serve event 0 per link, 6-11 event 1 per link,
    // 12 and 13 are the single shared banks of events 2 and 3.
    wire [`EEM_NUM_BANKS*32-1:0] mask_a;
    wire [`EEM_NUM_BANKS*32-1:0] mask_b;
    wire [`EEM_NUM_EVENTS*32-1:0] mask_c;

    genvar g;
    generate
        for (g = 0; g < `EEM_NUM_BANKS; g = g + 1) begin : g_link_bank
            // R03 R04 R05
            eem_mask_reg #(
                .IMPL(`EEM_A_IMPL),
                .RESET_VAL(`EEM_MASK_RESET)
            ) u_mask_a (
                .clk(clk),
                .rst_b(rst_b),
                .set_en(wr_take & hit_a_set & (idx_a_set == g)),
                .clr_en(wr_take & hit_a_clr & (idx_a_clr == g)),
                .wr_data(wb_dat_i),
                .lane_mask(lanes),
                .mask_q(mask_a[g*32 +: 32])
            );
            // R11 R04 R06 R07 R08 R09 R10
            eem_mask_reg #(
                .IMPL(`EEM_B_IMPL),
                .RESET_VAL(`EEM_MASK_RESET)
            ) u_mask_b (
                .clk(clk),
                .rst_b(rst_b),
                .set_en(wr_take & hit_b_set & (idx_b_set == g)),
                .clr_en(wr_take & hit_b_clr & (idx_b_clr == g)),
                .wr_data(wb_dat_i),
                .lane_mask(lanes),
                .mask_q(mask_b[g*32 +: 32])
            );
        end
        for (g = 0; g < `EEM_NUM_EVENTS; g = g + 1) begin : g_common_bank
            // R12 R13 R14 R16
            eem_mask_reg #(
                .IMPL(`EEM_C_IMPL),
                .RESET_VAL(`EEM_MASK_RESET)
            ) u_mask_c (
                .clk(clk),
                .rst_b(rst_b),
                .set_en(wr_take & hit_c_set & (idx_c_set == g)),
                .clr_en(wr_take & hit_c_clr & (idx_c_clr == g)),
                .wr_data(wb_dat_i),
                .lane_mask(lanes),
                .mask_q(mask_c[g*32 +: 32])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Event aggregation
    // ------------------------------------------------------------------
    // Raw status comes from logic on this clock, so it is not resynced.
    // Events 2 and 3 apply their shared bank to every link alike.
    wire [`EEM_NUM_EVENTS*NL-1:0] link_hit;
    wire [`EEM_NUM_EVENTS*32-1:0] common_msts;
    wire [3:0] event_nxt;

    genvar e;
    genvar l;
    generate
        for (e = 0; e < `EEM_NUM_EVENTS; e = e + 1) begin : g_event
            for (l = 0; l < NL; l = l + 1) begin : g_link
                localparam integer BANK = (e < 2) ? (e * NL + l)
                                        : (`EEM_SHARED_BANK + e - 2);
                assign link_hit[e*NL+l] =
                    (|(link_raw_a[l*32 +: 32] & mask_a[BANK*32 +: 32])) |
                    (|(link_raw_b[l*32 +: 32] & mask_b[BANK*32 +: 32])); // R15
            end
            assign common_msts[e*32 +: 32] =
                common_raw & mask_c[e*32 +: 32]; // R15
            assign event_nxt[e] = (|link_hit[e*NL +: NL]) |
                                  (|common_msts[e*32 +: 32]); // R19
        end
    endgenerate

    always @(posedge clk) begin
        if (!rst_b) begin
            antenna_event_out <= 4'h0;
        end else begin
            antenna_event_out <= event_nxt; // R19
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    wire [3:0] irq_sts;
    wire [3:0] irq_en;
    wire irq_q;

    eem_irq #(
        .N(`EEM_NUM_EVENTS)
    ) u_irq (
        .clk(clk),
        .rst_b(rst_b),
        .evt(antenna_event_out),
        .clr_wr(wr_take & hit_irq_clr & wb_sel_i[0]),
        .en_wr(wr_take & hit_irq_en & wb_sel_i[0]),
        .wr_data(wb_dat_i[3:0]),
        .sts_r(irq_sts),
        .en_r(irq_en),
        .irq_r(irq_q)
    );

    assign irq_o = irq_q;

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    // Set and clear aliases both return the live mask, never the last
    // written data; unmapped and write-only words return zero.
    reg [31:0] rd_data;

    always @* begin
        rd_data = 32'h0000_0000;
        if (hit_a_set) begin
            rd_data = mask_a[idx_a_set*32 +: 32]; // R02
        end else if (hit_b_set) begin
            rd_data = mask_b[idx_b_set*32 +: 32]; // R02
        end else if (hit_c_set) begin
            rd_data = mask_c[idx_c_set*32 +: 32]; // R02
        end else if (hit_a_clr) begin
            rd_data = mask_a[idx_a_clr*32 +: 32]; // R17
        end else if (hit_b_clr) begin
            rd_data = mask_b[idx_b_clr*32 +: 32]; // R17
        end else if (hit_c_clr) begin
            rd_data = mask_c[idx_c_clr*32 +: 32]; // R17
        end else if (hit_c_msts) begin
            rd_data = common_msts[idx_c_msts*32 +: 32];
        end else if (hit_irq_sts) begin
            rd_data = {28'h0000000, irq_sts};
        end else if (hit_irq_en) begin
            rd_data = {28'h0000000, irq_en};
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req_take;
            if (req_take && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/eem_props.sv
// Port-level concurrent checks for the event mask-set block
`timescale 1ns/1ps
`default_nettype none
`include "eem_regs.vh"
module eem_props #(
    parameter NL = 6
) (
    input wire clk, // System clock
    input wire rst_b, // Synchronous reset, active low
    input wire wb_cyc_i, // Bus cycle
    input wire wb_stb_i, // Bus strobe
    input wire wb_we_i, // Bus write enable
    input wire [11:0] wb_adr_i, // Bus byte address
    input wire [3:0] wb_sel_i, // Bus byte selects
    input wire [31:0] wb_dat_i, // Bus write data
    input wire [31:0] wb_dat_o, // Bus read data
    input wire wb_ack_o, // Bus acknowledge
    input wire [NL*32-1:0] link_raw_a, // Raw status A
    input wire [NL*32-1:0] link_raw_b, // Raw status B
    input wire [31:0] common_raw, // Common raw status
    input wire [3:0] antenna_event_out, // Event outputs
    input wire irq_o // Level interrupt
);
    // ------
    // Last write and whether it was full-word, for read-back checks
    // ------
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    reg [11:0] wr_adr_r;
    reg [31:0] wr_dat_r;
    reg wr_full_r;
    always @(posedge clk) begin
        if (!rst_b) begin
            wr_full_r <= 1'b0;
        end else if (take && wb_we_i) begin
            wr_adr_r <= wb_adr_i;
            wr_dat_r <= wb_dat_i;
            wr_full_r <= (wb_sel_i == 4'hf);
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_read;
        s_take ##0 !wb_we_i;
    endsequence
    chk_ack_pulse: assert property (s_take |=> s_pulse)
        else $error("ack is not a single pulse after a request");
    chk_ack_cause: assert property (wb_ack_o |-> $past(take))
        else $error("ack without a request");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside the ack cycle");
    chk_event_cause: assert property (antenna_event_out != 4'h0
        |-> $past(|{link_raw_a, link_raw_b, common_raw}))
        else $error("event raised with no raw status");
    chk_a_reserved: assert property (s_read ##0 wb_adr_i[11:6] == 6'h0
        |=> (wb_dat_o & ~`EEM_A_IMPL) == 32'h0)
        else $error("reserved bit set in an A mask read");
    chk_b_reserved: assert property (s_read ##0 wb_adr_i[11:6] == 6'h1
        |=> (wb_dat_o & ~`EEM_B_IMPL) == 32'h0)
        else $error("reserved bit set in a B mask read");
    chk_c_reserved: assert property (s_read ##0 wb_adr_i[11:6] == 6'h2
        |=> (wb_dat_o & ~`EEM_C_IMPL) == 32'h0)
        else $error("reserved bit set in a common mask read");
    chk_clr_reads: assert property (s_read ##0 wb_adr_i == 12'h204
        |=> wb_dat_o == 32'h0)
        else $error("interrupt clear register read not zero");
    chk_set_readback: assert property (s_read ##0 (wr_full_r
        && wb_adr_i == wr_adr_r && wb_adr_i < 12'h038)
        |=> (wb_dat_o & wr_dat_r & `EEM_A_IMPL) == (wr_dat_r & `EEM_A_IMPL))
        else $error("written one not read back from an A mask");
endmodule
`default_nettype wire

// file: verification/tb_error_event_mask_set.sv
// Self-checking bench for the event mask-set block
`timescale 1ns/1ps
`default_nettype none
`include "eem_regs.vh"
module tb_error_event_mask_set;
    localparam NL = 6;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h0;
    logic [3:0] sel = 4'hf;
    logic [3:0] sel_v = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [NL*32-1:0] raw_a = '0;
    logic [NL*32-1:0] raw_b = '0;
    logic [31:0] craw = 32'h0;
    wire [31:0] dat_o;
    wire ack;
    wire [3:0] evt;
    wire irq;
    integer n_errors = 0;
    integer num_checks = 0;
    always #2 clk = ~clk;
    eem_top #(.NL(NL)) DUT (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .link_raw_a(raw_a), .link_raw_b(raw_b), .common_raw(craw),
        .antenna_event_out(evt), .irq_o(irq));
    // ------
    // Bus and compare helpers
    // ------
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task wb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
        integer i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= sel_v;
        dat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            n_errors++;
            $display("[ERR] ack expected 1 seen %b", ack);
            print_verdict;
        end else begin
            q = dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(n, e, q);
    endtask
    task settle;
        repeat (4) @(posedge clk);
    endtask
    // ------
    // Scenarios
    // ------
    task t_reset_vals;
        for (int k = 0; k < 14; k++) begin
            rdc("a_mask", 12'(4 * k), 32'h0);
            rdc("b_mask", 12'h040 + 12'(4 * k), 32'h0);
        end
        for (int e = 0; e < 4; e++)
            rdc("c_mask", 12'h080 + 12'(4 * e), 32'h0);
        wr(12'h3f0, 32'hffff_ffff);
        rdc("unmapped", 12'h3f0, 32'h0);
        $display("t_reset_vals done");
    endtask
    task t_copies;
        for (int k = 0; k < 14; k++) begin
            wr(12'(4 * k), 32'h1 << k);
            wr(12'h040 + 12'(4 * k), (k + 1) << 8);
        end
        for (int k = 0; k < 14; k++) begin
            rdc("a_copy", 12'(4 * k), (32'h1 << k) & `EEM_A_IMPL);
            rdc("b_copy", 12'h040 + 12'(4 * k),
                ((k + 1) << 8) & `EEM_B_IMPL);
        end
        wr(12'h000, 32'h0);
        rdc("a_zero_wr", 12'h000, 32'h1);
        wr(12'h034, 32'hffff_ffff);
        rdc("a_full", 12'h034, `EEM_A_IMPL);
        wr(12'h074, 32'hffff_ffff);
        rdc("b_full", 12'h074, `EEM_B_IMPL);
        wr(12'h080, 32'hffff_ffff);
        rdc("c_full", 12'h080, `EEM_C_IMPL);
        sel_v = 4'h1;
        wr(12'h084, 32'hffff_ffff);
        sel_v = 4'hf;
        rdc("c_lane", 12'h084, `EEM_C_IMPL & 32'hff);
        $display("t_copies done");
    endtask
    task t_clear;
        wr(12'h100, 32'hffff_ffff);
        rdc("a_cleared", 12'h000, 32'h0);
        rdc("a_clr_alias", 12'h134, `EEM_A_IMPL);
        wr(12'h134, 32'h1);
        rdc("a_one_clr", 12'h034, `EEM_A_IMPL & ~32'h1);
        $display("t_clear done");
    endtask
    task t_events;
        for (int k = 0; k < 14; k++) begin
            wr(12'h100 + 12'(4 * k), 32'hffff_ffff);
            wr(12'h140 + 12'(4 * k), 32'hffff_ffff);
        end
        for (int e = 0; e < 4; e++)
            wr(12'h180 + 12'(4 * e), 32'hffff_ffff);
        raw_a <= '0;
        raw_a[64] <= 1'b1;
        settle;
        check("evt_masked", 32'h0, {28'h0, evt});
        wr(12'h208, 32'h1);
        rdc("irq_en", 12'h208, 32'h1);
        wr(12'h008, 32'h1);
        settle;
        check("evt_link2", 32'h1, {28'h0, evt});
        check("irq_on", 32'h1, {31'h0, irq});
        wr(12'h030, 32'h1);
        settle;
        check("evt_shared", 32'h5, {28'h0, evt});
        raw_a <= '0;
        raw_b[184] <= 1'b1;
        craw[25] <= 1'b1;
        wr(12'h074, 32'h1 << 24);
        wr(12'h084, 32'h1 << 25);
        settle;
        check("evt_b_c", 32'ha, {28'h0, evt});
        rdc("c_msts1", 12'h0c4, 32'h0200_0000);
        rdc("c_msts0", 12'h0c0, 32'h0);
        rdc("irq_sticky", 12'h200, 32'hf);
        raw_b <= '0;
        craw <= 32'h0;
        wr(12'h204, 32'hffff_ffff);
        settle;
        check("irq_clear", 32'h0, {31'h0, irq});
        wr(12'h208, 32'h0);
        raw_b[184] <= 1'b1;
        settle;
        check("evt_again", 32'h8, {28'h0, evt});
        check("irq_masked", 32'h0, {31'h0, irq});
        rdc("irq_sts", 12'h200, 32'h8);
        $display("t_events done");
    endtask
    task t_mid_reset;
        wr(12'h080, 32'hffff_ffff);
        craw <= 32'hffff_ffff;
        settle;
        check("evt_pre_rst", 32'hb, {28'h0, evt});
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("evt_post_rst", 32'h0, {28'h0, evt});
        check("irq_post_rst", 32'h0, {31'h0, irq});
        rdc("a_post_rst", 12'h030, 32'h0);
        rdc("c_post_rst", 12'h080, 32'h0);
        rdc("sts_post_rst", 12'h200, 32'h0);
        craw <= 32'h0;
        $display("t_mid_reset done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_vals;
        t_copies;
        t_clear;
        t_events;
        t_mid_reset;
        print_verdict;
    end
endmodule
bind eem_top eem_props #(.NL(NL)) u_props (.clk(clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_raw_a(link_raw_a),
    .link_raw_b(link_raw_b), .common_raw(common_raw),
    .antenna_event_out(antenna_event_out), .irq_o(irq_o));
`default_nettype wire
